// File: hw/vis_select.sv
// virtual-domain interrupt select: private redirection, candidate scan, masking and signalling
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "vis_cfg.svh"
// Behaviour
// RL1: non-secure, source 30 injected: its pending drives virtual 26.
// RL2: non-secure, source 27 injected: its pending drives virtual 28.
// RL3: secure, source 30 injected: its pending drives virtual 20.
// RL4: secure, source 27 injected: its pending drives virtual 19.
// RL5: target guest pending aliases physical source; source keeps its own stored state.
// RL6: target inject bit acts as 0, but reads back as stored.
// RL7: hypervisor pending fields always read and write as stored.
// RL8: redirected target ignores stored hypervisor pending, uses physical source only.
// RL9: virtual priority mask comes from the mask register.
// RL10: running priority is highest active priority, reported in a register.
// RL11: sufficient means strictly above running priority and at or above mask.
// RL12: highest-pending report shows valid and number only when sufficient.
// RL13: highest pending exists only with both enables set and a candidate.
// RL14: winner is higher-priority of infrastructure and best private candidate.
// RL15: infrastructure candidate excluded when its disable bit is 1.
// RL16: without hypervisor level the hypervisor enable acts as 0.
// RL17: equal priorities: infrastructure candidate wins, fixed.
// RL18: selection determined and redetermined within a bounded number of cycles.
// RL19: virtual normal interrupt raised when a sufficient highest pending exists.
// RL20: virtual fast interrupt is never raised.
// RL21: superpriority decided whenever the virtual normal interrupt is signalled.
// RL22: superpriority needs priority 0, guest kernel or lower, nonmaskable enable.
// RL23: redirection only with nested controls {1,0} and hypervisor level enabled.
// RL24: numerically smaller priority is the higher priority.
// RL25: clear inject bit: no redirection, own stored pending used.
module vis_select #(
  parameter int ID_W     = 24,
  parameter bit HYP_IMPL = 1'b1
) (
  input  wire logic            clock,                  // core clock, 125 MHz
  input  wire logic            resetn,                 // async reset, active low
  input  wire logic [7:0]      regAddr,                // register byte address
  input  wire logic [31:0]     regWdata,               // register write data
  input  wire logic            regWrite,               // write strobe
  input  wire logic            regRead,                // read strobe
  output logic      [31:0]     regRdata,               // read data, cycle after strobe
  input  wire logic [31:0]     physPending,            // physical private pending state
  input  wire logic            infraValid,             // infrastructure candidate present
  input  wire logic [ID_W-1:0] infraId,                // infrastructure candidate number
  input  wire logic [4:0]      infraPrio,              // infrastructure candidate priority
  input  wire logic            nonsecureSelect,        // security state select
  input  wire logic            nestedVirtNv,           // nested virtualisation control
  input  wire logic            nestedVirtNv1,          // nested virtualisation control
  input  wire logic            hypEnabled,             // hypervisor level enabled here
  input  wire logic            guestKernelOrLower,     // executing at guest kernel or lower
  input  wire logic            guestNonmaskableEnable, // guest nonmaskable enable
  output logic                 virqOut,                // virtual normal interrupt
  output logic                 vfiqOut,                // virtual fast interrupt
  output logic                 vnmiOut                 // superpriority on virtual normal
);
  logic [2:0]         ctrl;
  logic [31:0]        directInject;
  logic [31:0]        hypPending;
  logic [31:0]        privEnable;
  vis_pkg::vis_prio_t prioMask;
  logic [31:0]        activePrio;
  logic [31:0]        highestReport;

  vis_pkg::vis_scan_t scanState;
  logic [4:0]         scanIdx;
  logic [4:0]         evalIdx;
  logic               evalValid;
  logic               bestValid;
  logic [4:0]         bestIdx;
  vis_pkg::vis_prio_t bestPrio;
  logic               candValid;
  logic [4:0]         candIdx;
  vis_pkg::vis_prio_t candPrio;
  vis_pkg::vis_prio_t memRdata;

  // redirect target of a source number for the selected security state
  function automatic logic [4:0] redirectTarget(input logic [4:0] src, input logic ns);
    if (src == `VIS_SRC_A) begin
      redirectTarget = ns ? `VIS_TGT_A_NS : `VIS_TGT_A_S;
    end else begin
      redirectTarget = ns ? `VIS_TGT_B_NS : `VIS_TGT_B_S;
    end
  endfunction

  wire        guestEn   = ctrl[`VIS_CTRL_GUEST_EN_BIT];
  wire        hypEnEff  = ctrl[`VIS_CTRL_HYP_EN_BIT] && HYP_IMPL && hypEnabled; // [RL16]
  wire        infraDis  = ctrl[`VIS_CTRL_INFRA_DIS_BIT];
  wire [31:0] dviEff    = HYP_IMPL ? directInject : 32'h0000_0000;
  wire        nestedOn  = nestedVirtNv && !nestedVirtNv1 && HYP_IMPL && hypEnabled; // [RL23]
  wire        redirA    = nestedOn && dviEff[`VIS_SRC_A]; // [RL25]
  wire        redirB    = nestedOn && dviEff[`VIS_SRC_B]; // [RL25]
  wire [4:0]  tgtA      = redirectTarget(`VIS_SRC_A, nonsecureSelect); // [RL1] [RL3]
  wire [4:0]  tgtB      = redirectTarget(`VIS_SRC_B, nonsecureSelect); // [RL2] [RL4]

  // per-bit effective pending: direct injection, redirection overlay, else stored state
  wire [31:0] effPending;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_pend
      wire isTgtA  = redirA && (tgtA == 5'(gi));
      wire isTgtB  = redirB && (tgtB == 5'(gi));
      wire isSrc   = (redirA && gi == 30) || (redirB && gi == 27);
      wire useDvi  = dviEff[gi] && !isTgtA && !isTgtB && !isSrc; // [RL6]
      wire ownPend = useDvi ? physPending[gi] : hypPending[gi]; // [RL5] [RL25]
      assign effPending[gi] = isTgtA ? physPending[30] : isTgtB ? physPending[27] : ownPend; // [RL8]
    end
  endgenerate

  // running priority is the lowest set bit of the active priorities
  vis_pkg::vis_rprio_t runPrio;
  always_comb begin
    runPrio = `VIS_PRIO_IDLE;
    for (int i = 31; i >= 0; i--) begin
      if (activePrio[i]) begin
        runPrio = 6'(i); // [RL10]
      end
    end
  end

  // register decode
  wire        prioWr    = regWrite && regAddr[`VIS_PRIO_TABLE_BIT];
  wire        selCtrl   = regAddr == `VIS_OFF_CTRL;
  wire        selDvi    = regAddr == `VIS_OFF_DIRECT_INJECT;
  wire        selHpend  = regAddr == `VIS_OFF_HYP_PENDING;
  wire        selEnable = regAddr == `VIS_OFF_ENABLE;
  wire        selMask   = regAddr == `VIS_OFF_PRIO_MASK;
  wire        selApr    = regAddr == `VIS_OFF_ACTIVE_PRIO;
  logic [31:0] readMux;
  always_comb begin
    unique case (regAddr)
      `VIS_OFF_CTRL:          readMux = {29'h0, ctrl};
      `VIS_OFF_DIRECT_INJECT: readMux = directInject; // [RL6]
      `VIS_OFF_HYP_PENDING:   readMux = hypPending; // [RL7]
      `VIS_OFF_GUEST_PENDING: readMux = effPending; // [RL5]
      `VIS_OFF_ENABLE:        readMux = privEnable;
      `VIS_OFF_PRIO_MASK:     readMux = {27'h0, prioMask};
      `VIS_OFF_ACTIVE_PRIO:   readMux = activePrio;
      `VIS_OFF_RUN_PRIO:      readMux = {26'h0, runPrio}; // [RL10]
      `VIS_OFF_HIGHEST:       readMux = highestReport; // [RL12]
      default:                readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl         <= `VIS_RST_CTRL;
      directInject <= '0;
      hypPending   <= '0;
      privEnable   <= '0;
      prioMask     <= `VIS_RST_PRIO_MASK;
      activePrio   <= '0;
      regRdata     <= '0;
    end else begin
      if (regWrite && selCtrl) ctrl <= regWdata[2:0];
      if (regWrite && selDvi) directInject <= regWdata;
      if (regWrite && selHpend) hypPending <= regWdata; // [RL7]
      if (regWrite && selEnable) privEnable <= regWdata;
      if (regWrite && selMask) prioMask <= regWdata[4:0]; // [RL9]
      if (regWrite && selApr) activePrio <= regWdata;
      regRdata <= regRead ? readMux : 32'h0000_0000;
    end
  end

  vis_prio_mem #(.W(5), .DEPTH(32), .AW(5)) u_prio (
    .clock  (clock),
    .resetn (resetn),
    .we     (prioWr),
    .waddr  (regAddr[6:2]),
    .wdata  (regWdata[4:0]),
    .raddr  (scanIdx),
    .rdata  (memRdata)
  );

  // sweep over the priority table, one entry a cycle, keeping the best eligible one
  wire evalHit  = evalValid && effPending[evalIdx] && privEnable[evalIdx];
  wire evalWins = evalHit && (!bestValid || memRdata < bestPrio); // [RL24]
  vis_pkg::vis_scan_t next_scanState;
  always_comb begin
    unique case (scanState)
      vis_pkg::VIS_SWEEP:   next_scanState = (scanIdx == `VIS_PPI_LAST) ? vis_pkg::VIS_DRAIN : vis_pkg::VIS_SWEEP;
      vis_pkg::VIS_DRAIN:   next_scanState = vis_pkg::VIS_PUBLISH;
      vis_pkg::VIS_PUBLISH: next_scanState = vis_pkg::VIS_SWEEP;
      default:              next_scanState = vis_pkg::VIS_SWEEP;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scanState <= vis_pkg::VIS_SWEEP;
      scanIdx   <= '0;
      evalIdx   <= '0;
      evalValid <= 1'b0;
    end else begin
      scanState <= next_scanState; // [RL18]
      scanIdx   <= (scanState == vis_pkg::VIS_SWEEP) ? scanIdx + 5'h01 : 5'h00;
      evalIdx   <= scanIdx;
      evalValid <= scanState == vis_pkg::VIS_SWEEP;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bestValid <= 1'b0;
      bestIdx   <= '0;
      bestPrio  <= '0;
      candValid <= 1'b0;
      candIdx   <= '0;
      candPrio  <= '0;
    end else if (scanState == vis_pkg::VIS_PUBLISH) begin
      candValid <= bestValid;
      candIdx   <= bestIdx;
      candPrio  <= bestPrio;
      bestValid <= 1'b0;
    end else if (evalWins) begin
      bestValid <= 1'b1;
      bestIdx   <= evalIdx;
      bestPrio  <= memRdata;
    end
  end

  // a published candidate that stopped pending or was disabled is dropped at once
  wire candLive = candValid && effPending[candIdx] && privEnable[candIdx];

  vis_cand_if #(.ID_W(ID_W)) cand ();
  assign cand.infraValid = infraValid && !infraDis; // [RL15]
  assign cand.infraId    = infraId;
  assign cand.infraPrio  = infraPrio;
  assign cand.ppiValid   = candLive;
  assign cand.ppiId      = ID_W'(candIdx);
  assign cand.ppiPrio    = candPrio;

  vis_arbiter u_arb (
    .cand (cand)
  );

  wire hppiExists = guestEn && hypEnEff && cand.winValid; // [RL13]
  wire sufficient = ({1'b0, cand.winPrio} < runPrio) && (cand.winPrio <= prioMask); // [RL11] [RL24]
  wire signalIrq  = hppiExists && sufficient;
  wire superPrio  = signalIrq && cand.winPrio == 5'h00 && guestKernelOrLower && guestNonmaskableEnable;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      virqOut       <= 1'b0;
      vfiqOut       <= 1'b0;
      vnmiOut       <= 1'b0;
      highestReport <= '0;
    end else begin
      virqOut       <= signalIrq; // [RL19]
      vfiqOut       <= 1'b0; // [RL20]
      vnmiOut       <= superPrio; // [RL21] [RL22]
      highestReport <= signalIrq ? {1'b1, 31'(cand.winId)} : 32'h0000_0000; // [RL12]
    end
  end

  localparam int SWEEP_MAX = `VIS_SWEEP_BOUND;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_read_guest;
    regRead && regAddr == `VIS_OFF_GUEST_PENDING;
  endsequence
  sequence s_sweep_start;
    scanState == vis_pkg::VIS_SWEEP && scanIdx == 5'h00;
  endsequence
  sequence s_hpend_write;
    regWrite && regAddr == `VIS_OFF_HYP_PENDING;
  endsequence

  property p_ns_src_a;
    s_read_guest and (redirA && nonsecureSelect) |=> regRdata[26] == $past(physPending[30]);
  endproperty
  property p_ns_src_b;
    s_read_guest and (redirB && nonsecureSelect) |=> regRdata[28] == $past(physPending[27]);
  endproperty
  property p_s_src_a;
    s_read_guest and (redirA && !nonsecureSelect) |=> regRdata[20] == $past(physPending[30]);
  endproperty
  property p_s_src_b;
    s_read_guest and (redirB && !nonsecureSelect) |=> regRdata[19] == $past(physPending[27]);
  endproperty
  property p_src_own;
    s_read_guest and redirA |=> regRdata[30] == $past(hypPending[30]);
  endproperty
  property p_dvi_read;
    regRead && regAddr == `VIS_OFF_DIRECT_INJECT |=> regRdata == $past(directInject);
  endproperty
  property p_hpend_rw;
    s_hpend_write ##1 (regRead && regAddr == `VIS_OFF_HYP_PENDING && !regWrite) |=> regRdata == $past(regWdata, 2);
  endproperty
  property p_virtual_normal_interrupt_cause;
    virqOut |-> $past(hppiExists && cand.winPrio <= prioMask && {1'b0, cand.winPrio} < runPrio);
  endproperty
  property p_enables;
    !(guestEn && hypEnEff) |=> !virqOut && highestReport == 32'h0000_0000;
  endproperty
  property p_infra_off;
    infraDis && !candLive |=> !virqOut;
  endproperty
  property p_no_fiq;
    !vfiqOut;
  endproperty
  property p_nmi;
    vnmiOut |-> virqOut && $past(cand.winPrio == 5'h00 && guestKernelOrLower && guestNonmaskableEnable);
  endproperty
  property p_sweep_bound;
    s_sweep_start |-> ##[1:SWEEP_MAX] scanState == vis_pkg::VIS_PUBLISH;
  endproperty

  a_ns_src_a: assert property (p_ns_src_a) else $error("ns redirect of 30 to 26 wrong"); // [RL1]
  a_ns_src_b: assert property (p_ns_src_b) else $error("ns redirect of 27 to 28 wrong"); // [RL2]
  a_s_src_a: assert property (p_s_src_a) else $error("secure redirect of 30 to 20 wrong"); // [RL3]
  a_s_src_b: assert property (p_s_src_b) else $error("secure redirect of 27 to 19 wrong"); // [RL4]
  a_src_own: assert property (p_src_own) else $error("source pending lost its own state"); // [RL5]
  a_dvi_read: assert property (p_dvi_read) else $error("inject enable read not stored value"); // [RL6]
  a_hpend_rw: assert property (p_hpend_rw) else $error("hypervisor pending not stored"); // [RL7]
  a_virtual_normal_interrupt_cause: assert property (p_virtual_normal_interrupt_cause) else $error("virtual_normal_interrupt without sufficient priority"); // [RL11]
  a_enables: assert property (p_enables) else $error("virtual_normal_interrupt with an enable clear"); // [RL13]
  a_infra_off: assert property (p_infra_off) else $error("disabled infrastructure candidate used"); // [RL15]
  a_no_fiq: assert property (p_no_fiq) else $error("virtual fast interrupt raised"); // [RL20]
  a_nmi: assert property (p_nmi) else $error("superpriority without its conditions"); // [RL22]
  a_sweep_bound: assert property (p_sweep_bound) else $error("private scan did not publish in time"); // [RL18]
endmodule

// File: hw/vis_cfg.svh
// offsets, field positions, reset values and counts of the virtual interrupt select block
`ifndef VIS_CFG_SVH
`define VIS_CFG_SVH
`define VIS_OFF_CTRL           8'h00
`define VIS_OFF_DIRECT_INJECT  8'h04
`define VIS_OFF_HYP_PENDING    8'h08
`define VIS_OFF_GUEST_PENDING  8'h0c
`define VIS_OFF_ENABLE         8'h10
`define VIS_OFF_PRIO_MASK      8'h14
`define VIS_OFF_ACTIVE_PRIO    8'h18
`define VIS_OFF_RUN_PRIO       8'h1c
`define VIS_OFF_HIGHEST        8'h20
`define VIS_PRIO_TABLE_BIT     7
`define VIS_CTRL_GUEST_EN_BIT  0
`define VIS_CTRL_HYP_EN_BIT    1
`define VIS_CTRL_INFRA_DIS_BIT 2
`define VIS_HIGHEST_VALID_BIT  31
`define VIS_RST_CTRL           3'h0
`define VIS_RST_PRIO_MASK      5'h1f
`define VIS_PRIO_IDLE          6'h20
`define VIS_PPI_LAST           5'h1f
`define VIS_SRC_A              5'h1e
`define VIS_SRC_B              5'h1b
`define VIS_TGT_A_NS           5'h1a
`define VIS_TGT_B_NS           5'h1c
`define VIS_TGT_A_S            5'h14
`define VIS_TGT_B_S            5'h13
`define VIS_SWEEP_BOUND        40
`endif

// File: hw/vis_pkg.sv
// types shared by the virtual interrupt select block
package vis_pkg;
  typedef logic [4:0] vis_prio_t;
  typedef logic [5:0] vis_rprio_t;
  typedef enum logic [2:0] {
    VIS_SWEEP   = 3'b001,
    VIS_DRAIN   = 3'b010,
    VIS_PUBLISH = 3'b100
  } vis_scan_t;
endpackage

// File: hw/vis_cand_if.sv
// candidate bundle between the select block and its arbiter
`timescale 1ns/1ps
interface vis_cand_if #(parameter int ID_W = 24);
  logic                infraValid;
  logic [ID_W-1:0]     infraId;
  vis_pkg::vis_prio_t  infraPrio;
  logic                ppiValid;
  logic [ID_W-1:0]     ppiId;
  vis_pkg::vis_prio_t  ppiPrio;
  logic                winValid;
  logic [ID_W-1:0]     winId;
  vis_pkg::vis_prio_t  winPrio;
  modport arb (input infraValid, infraId, infraPrio, ppiValid, ppiId, ppiPrio,
               output winValid, winId, winPrio);
  modport top (output infraValid, infraId, infraPrio, ppiValid, ppiId, ppiPrio,
               input winValid, winId, winPrio);
endinterface

// File: hw/vis_prio_mem.sv
// private interrupt priority table with registered read port
`timescale 1ns/1ps
module vis_prio_mem #(
  parameter int W     = 5,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clock,   // core clock
  input  wire logic          resetn,  // async reset, active low
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] waddr,   // write index
  input  wire logic [W-1:0]  wdata,   // write priority
  input  wire logic [AW-1:0] raddr,   // read index
  output logic      [W-1:0]  rdata    // priority, one cycle after raddr
);
  logic [W-1:0] store [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= store[raddr];
    end
  end
endmodule

// File: hw/vis_arbiter.sv
// picks the higher-priority of the infrastructure and private candidates
`timescale 1ns/1ps
module vis_arbiter (
  vis_cand_if.arb cand  // candidates in, winner out
);
  logic infraWins;

  // smaller value is higher priority; on a tie the infrastructure candidate wins
  assign infraWins = cand.infraValid && (!cand.ppiValid || cand.infraPrio <= cand.ppiPrio); // [RL14] [RL17] [RL24]
  assign cand.winValid = cand.infraValid || cand.ppiValid;
  assign cand.winId    = infraWins ? cand.infraId : cand.ppiId;
  assign cand.winPrio  = infraWins ? cand.infraPrio : cand.ppiPrio;
endmodule

// File: dv/vis_infra_model.sv
// behavioural routing infrastructure presenting one candidate to the select block
`timescale 1ns/1ps
module vis_infra_model (
  input  wire logic        clock,      // core clock
  input  wire logic        resetn,     // async reset, active low
  input  wire logic        reqValid,   // bench wants a candidate shown
  input  wire logic [23:0] reqId,      // wanted candidate number
  input  wire logic [4:0]  reqPrio,    // wanted candidate priority
  input  wire logic        slow,       // present after a delay
  output logic             infraValid, // candidate present
  output logic      [23:0] infraId,    // candidate number
  output logic      [4:0]  infraPrio   // candidate priority
);
  logic [1:0] waitCnt;
  wire        same = infraValid && infraId == reqId && infraPrio == reqPrio;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      infraValid <= 1'b0;
      infraId    <= 24'h0;
      infraPrio  <= 5'h0;
      waitCnt    <= 2'h0;
    end else if (reqValid && !same) begin
      if (slow && waitCnt != 2'h3) begin
        waitCnt <= waitCnt + 2'h1;
      end else begin
        infraValid <= 1'b1;
        infraId    <= reqId;
        infraPrio  <= reqPrio;
        waitCnt    <= 2'h0;
      end
    end else if (!reqValid) begin
      // no candidate: number and priority lines churn so stale values never look valid
      infraValid <= 1'b0;
      infraId    <= ~infraId;
      infraPrio  <= ~infraPrio;
      waitCnt    <= 2'h0;
    end
  end
endmodule

// File: dv/vis_select_tb_top.sv
// self-checking bench of the virtual interrupt select block
`timescale 1ns/1ps
`include "vis_cfg.svh"
module vis_select_tb_top;
  logic        clock, resetn, regWrite, regRead, reqValid, slow, hypEnabled;
  logic        nonsecureSelect, nestedVirtNv, nestedVirtNv1, guestKernelOrLower, guestNonmaskableEnable;
  logic        infraValid, virqOut, vfiqOut, vnmiOut, eVirq, eVnmi;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, physPending, hyp, inj, en, apr, eRep;
  logic [23:0] infraId, reqId;
  logic [4:0]  infraPrio, reqPrio, mask;
  logic [4:0]  prioTab [32];
  logic [2:0]  ctrl;
  int          nMismatch, checkCount;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  vis_select #(.ID_W(24), .HYP_IMPL(1'b1)) dut_u (.clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .physPending(physPending), .infraValid(infraValid), .infraId(infraId), .infraPrio(infraPrio),
    .nonsecureSelect(nonsecureSelect), .nestedVirtNv(nestedVirtNv), .nestedVirtNv1(nestedVirtNv1),
    .hypEnabled(hypEnabled), .guestKernelOrLower(guestKernelOrLower),
    .guestNonmaskableEnable(guestNonmaskableEnable), .virqOut(virqOut), .vfiqOut(vfiqOut), .vnmiOut(vnmiOut));
  vis_infra_model model_u (.clock(clock), .resetn(resetn), .reqValid(reqValid), .reqId(reqId),
    .reqPrio(reqPrio), .slow(slow), .infraValid(infraValid), .infraId(infraId), .infraPrio(infraPrio));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // write, then read the same offset back to back
  task automatic wrrd(input string nm, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead  <= 1'b1;
    @(posedge clock);
    regRead  <= 1'b0;
    @(negedge clock);
    chk(nm, d, regRdata);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk(nm, e, regRdata);
  endtask
  function automatic logic [31:0] effPend();
    logic [31:0] p;
    p = (inj & physPending) | (~inj & hyp);
    if (nestedVirtNv && !nestedVirtNv1 && hypEnabled) begin
      if (inj[30]) begin
        p[30] = hyp[30];
        p[nonsecureSelect ? 26 : 20] = physPending[30];
      end
      if (inj[27]) begin
        p[27] = hyp[27];
        p[nonsecureSelect ? 28 : 19] = physPending[27];
      end
    end
    return p;
  endfunction
  function automatic logic [5:0] runPrio();
    logic [5:0] r;
    r = 6'h20;
    for (int i = 31; i >= 0; i--) if (apr[i]) r = 6'(i);
    return r;
  endfunction
  function automatic void expOut();
    logic [31:0] p;
    logic [5:0]  bp;
    logic [30:0] id;
    p  = effPend() & en;
    bp = 6'h20;
    id = 31'h0;
    for (int i = 0; i < 32; i++) begin
      if (p[i] && {1'b0, prioTab[i]} < bp) begin
        bp = {1'b0, prioTab[i]};
        id = 31'(i);
      end
    end
    // infrastructure wins a tie
    if (reqValid && !ctrl[2] && {1'b0, reqPrio} <= bp) begin
      bp = {1'b0, reqPrio};
      id = {7'h0, reqId};
    end
    eVirq = ctrl[0] && ctrl[1] && hypEnabled && bp < runPrio() && bp <= {1'b0, mask};
    eVnmi = eVirq && bp == 6'h0 && guestKernelOrLower && guestNonmaskableEnable;
    eRep  = eVirq ? {1'b1, id} : 32'h0;
  endfunction
  task automatic run();
    wr(`VIS_OFF_DIRECT_INJECT, inj);
    wrrd("hyp_wr_rd", `VIS_OFF_HYP_PENDING, hyp);
    wr(`VIS_OFF_ENABLE, en);
    wr(`VIS_OFF_PRIO_MASK, {27'h0, mask});
    wr(`VIS_OFF_ACTIVE_PRIO, apr);
    wr(`VIS_OFF_CTRL, {29'h0, ctrl});
    // two full sweeps plus the slow candidate delay
    repeat (80) @(posedge clock);
    @(negedge clock);
    expOut();
    chk("virtual_normal_interrupt", {31'h0, eVirq}, {31'h0, virqOut});
    chk("vnmi", {31'h0, eVnmi}, {31'h0, vnmiOut});
    chk("virtual_fast_interrupt", 32'h0, {31'h0, vfiqOut});
    rdchk("guest_pend", `VIS_OFF_GUEST_PENDING, effPend());
    rdchk("run_prio", `VIS_OFF_RUN_PRIO, {26'h0, runPrio()});
    rdchk("highest", `VIS_OFF_HIGHEST, eRep);
    rdchk("inject_rb", `VIS_OFF_DIRECT_INJECT, inj);
    rdchk("hyp_rb", `VIS_OFF_HYP_PENDING, hyp);
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(8 * 50000);
    nMismatch++;
    summarize();
  end
  initial begin
    {resetn, regWrite, regRead, reqValid, slow, nonsecureSelect, nestedVirtNv, nestedVirtNv1} = 8'h0;
    {guestKernelOrLower, guestNonmaskableEnable} = 2'h0;
    hypEnabled  = 1'b1;
    regAddr     = 8'h0;
    regWdata    = 32'h0;
    physPending = 32'h0;
    reqId       = 24'h0;
    reqPrio     = 5'h0;
    void'($urandom(32'hf363b919));
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rdchk("ctrl_rst", `VIS_OFF_CTRL, 32'h0);
    rdchk("mask_rst", `VIS_OFF_PRIO_MASK, 32'h1f);
    rdchk("run_rst", `VIS_OFF_RUN_PRIO, 32'h20);
    rdchk("highest_rst", `VIS_OFF_HIGHEST, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(`VIS_OFF_RUN_PRIO, 32'hffffffff);
    rdchk("ro_run", `VIS_OFF_RUN_PRIO, 32'h20);
    $display("test reset_values done");
    for (int i = 0; i < 32; i++) begin
      prioTab[i] = 5'($urandom % 32);
      wr(8'(8'h80 + 4 * i), {27'h0, prioTab[i]});
    end
    rdchk("table_wo", 8'h80, 32'h0);
    for (int k = 0; k < 34; k++) begin
      @(posedge clock);
      hyp  = $urandom;
      inj  = (k < 8) ? ($urandom | 32'h48000000) : $urandom;
      en   = $urandom;
      // k == 8: priority 0 infrastructure candidate with everything open
      mask = (k == 8) ? 5'h1f : 5'($urandom);
      apr  = (k == 8) ? 32'h0 : 32'h1 << ($urandom % 33);
      ctrl = (k == 8) ? 3'h3 : ($urandom % 4 == 0) ? 3'($urandom) : {1'($urandom), 2'b11};
      physPending     <= $urandom;
      nonsecureSelect <= k[0];
      nestedVirtNv    <= (k < 8) ? 1'b1 : 1'($urandom);
      nestedVirtNv1   <= (k < 8) ? 1'b0 : 1'($urandom);
      hypEnabled      <= (k <= 8) || ($urandom % 4 != 0);
      reqValid        <= (k == 8) || 1'($urandom);
      reqId           <= 24'($urandom);
      reqPrio         <= (k == 8) ? 5'h0 : ($urandom % 2) ? prioTab[$urandom % 32] : 5'($urandom);
      slow            <= 1'($urandom);
      guestKernelOrLower     <= (k == 8) || 1'($urandom);
      guestNonmaskableEnable <= (k == 8) || 1'($urandom);
      run();
    end
    $display("test select_random done");
    summarize();
  end
endmodule
